// file: src/uart0_cfg.svh
`ifndef UART0_CFG_SVH
`define UART0_CFG_SVH

`define SFR_CKCON_ADDR 8'h8e
`define SFR_SCON_ADDR 8'h98
`define SFR_SBUF_ADDR 8'h99

`define SCON_RESET 8'h00
`define SBUF_RESET 8'h00
`define CKCON_T1M_RESET 1'b0

`define CKCON_T1M_BIT 4
`define SCON_SM0_BIT 7
`define SCON_SM1_BIT 6
`define SCON_SM2_BIT 5
`define SCON_REN_BIT 4
`define SCON_TB8_BIT 3
`define SCON_RB8_BIT 2
`define SCON_TI_BIT 1
`define SCON_RI_BIT 0

`define M0_SLOW_PCLK 12
`define M0_FAST_PCLK 4
`define M2_SLOW_PCLK 64
`define M2_FAST_PCLK 32
`define OVERSAMPLE 16
`define T1_SLOW_DIV 12
`define T1_FAST_DIV 4

`define FRAME_8_BITS 10
`define FRAME_9_BITS 11
`define M0_BITS 8
`define ASYNC_RX_BITS 9

`endif

// file: src/uart0_pkg.sv
package uart0_pkg;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_M0OUT = 2'b01,
        TX_M0IN = 2'b10,
        TX_ASYNC = 2'b11
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } rx_state_t;

endpackage

// file: src/uart0_tick_if.sv
`timescale 1ns/1ps
interface uart0_tick_if;
    logic m0_half;
    logic sample16;
    logic t1_tick;
    modport gen(output m0_half, output sample16, output t1_tick);
    modport core(input m0_half, input sample16, input t1_tick);
endinterface

// file: src/uart0_baud_gen.sv
`timescale 1ns/1ps
`include "uart0_cfg.svh"
module uart0_baud_gen (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] mode_in,
    input wire logic fast_m0_in,
    input wire logic baud_double_in,
    input wire logic t1_fast_in,
    input wire logic timer_one_ovf_in,
    uart0_tick_if.gen tick
);

    logic [5:0] div_ff;
    logic [5:0] lim;
    logic div_hit;
    logic ovf_half_ff;
    logic [3:0] t1_ff;
    logic [3:0] t1_lim;

    ////////////////////////////////////////////////////////////////////////
    // Fixed fractions of the peripheral clock
    always_comb begin
        case (mode_in)
            2'b00: lim = fast_m0_in ? 6'(`M0_FAST_PCLK / 2) : 6'(`M0_SLOW_PCLK / 2);
            2'b10: lim = baud_double_in ? 6'(`M2_FAST_PCLK / `OVERSAMPLE)
                                        : 6'(`M2_SLOW_PCLK / `OVERSAMPLE);
            default: lim = 6'd1;
        endcase
    end

    // Compare with >= so a mode change mid-count cannot overrun
    assign div_hit = (div_ff >= lim - 6'd1);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_ff <= 6'd0;
        end else if (div_hit) begin
            div_ff <= 6'd0;
        end else begin
            div_ff <= div_ff + 6'd1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ovf_half_ff <= 1'b0;
        end else if (timer_one_ovf_in) begin
            ovf_half_ff <= !ovf_half_ff;
        end
    end

    // Modes 1/3: overflow rate halved unless baud doubling
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick.m0_half <= 1'b0;
            tick.sample16 <= 1'b0;
        end else begin
            tick.m0_half <= (mode_in == 2'b00) && div_hit;
            if (mode_in == 2'b10) begin
                tick.sample16 <= div_hit;
            end else begin
                tick.sample16 <= mode_in[0] && timer_one_ovf_in
                                 && (baud_double_in || ovf_half_ff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer 1 input prescaler
    assign t1_lim = t1_fast_in ? 4'(`T1_FAST_DIV) : 4'(`T1_SLOW_DIV);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            t1_ff <= 4'd0;
            tick.t1_tick <= 1'b0;
        end else if (t1_ff >= t1_lim - 4'd1) begin
            t1_ff <= 4'd0;
            tick.t1_tick <= 1'b1;
        end else begin
            t1_ff <= t1_ff + 4'd1;
            tick.t1_tick <= 1'b0;
        end
    end

    m0_slow_a: assert property (@(posedge ref_clk_in)
        disable iff (rst_in || mode_in != 2'b00 || fast_m0_in)
        tick.m0_half |=> (!tick.m0_half)[*5] ##1 tick.m0_half)
        else $error("mode 0 half bit not 6 clocks");

    m2_sample_a: assert property (@(posedge ref_clk_in)
        disable iff (rst_in || mode_in != 2'b10 || baud_double_in)
        tick.sample16 |=> (!tick.sample16)[*3] ##1 tick.sample16)
        else $error("mode 2 sample spacing not 4 clocks");

    t1_fast_div_a: assert property (@(posedge ref_clk_in)
        disable iff (rst_in || !t1_fast_in)
        tick.t1_tick |=> (!tick.t1_tick)[*3] ##1 tick.t1_tick)
        else $error("timer one tick not every 4 clocks");

endmodule

// file: src/serial_port_zero_uart.sv
`timescale 1ns/1ps
`include "uart0_cfg.svh"
// How it works
// - The top two mode bits pick the mode, the third the mode 0 speed; mode 0 shifts 8 bits at 12 or 4 clocks a bit.
// - Modes 1 to 3 frame data with one start and one stop bit, 10 bits or 11 bits in all.
// - Mode 2 bits last 64 clocks, or 32 with baud doubling; modes 1 and 3 follow Timer 1.
// - Receive enable gates reception, and in mode 0 it starts a synchronous receive.
// - Modes 2 and 3 send the ninth transmit bit as the ninth data bit.
// - The ninth receive bit takes bit nine in modes 2 and 3 and the stop bit in mode 1.
// - Mode 0 raises transmit done at the end of the eighth bit.
// - Modes 1 to 3 raise transmit done at the end of the last data bit, before the stop.
// - Hardware never clears the done flags; software clears them by writing 0.
// - Mode 0 raises receive done after the eighth received bit.
// - Receive done follows the stop bit in mode 1 and the ninth bit in modes 2 and 3.
// - The Timer 1 clock select divides the clock by 12 or by 4.
// - The serial buffer address writes the transmit buffer and reads the receive buffer.
module serial_port_zero_uart (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic baud_double_in,
    input wire logic timer_one_ovf_in,
    output logic timer_one_tick_out,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_out,
    output logic txd_out
);

    logic [2:0] sm_ff;
    logic ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff, t1m_ff;
    logic [7:0] rx_buf_ff, rdata_ff;
    logic wr_scon, wr_sbuf, wr_ckcon;
    logic [1:0] mode;
    logic rxd_s1_ff, rxd_s2_ff, rxd_s3_ff, rxd_q_ff, rxd_d_ff;
    uart0_pkg::tx_state_t tx_st_ff;
    logic [10:0] tx_sh_ff;
    logic [3:0] tx_cnt_ff, tx_sub_ff;
    logic m0_phase_ff, txd_ff, rxd_o_ff, rxd_oe_ff;
    logic ti_set_ff, m0_done_ff, bit_end;
    uart0_pkg::rx_state_t rx_st_ff;
    logic [3:0] rx_sub_ff, rx_cnt_ff;
    logic [8:0] rx_sh_ff;
    logic [2:0] vote_ff;
    logic maj, async_done_ff, rx_accept, rxd_now;

    uart0_tick_if tick ();

    assign mode = sm_ff[2:1];
    assign wr_scon = sfr_wr_in && (sfr_addr_in == `SFR_SCON_ADDR);
    assign wr_sbuf = sfr_wr_in && (sfr_addr_in == `SFR_SBUF_ADDR);
    assign wr_ckcon = sfr_wr_in && (sfr_addr_in == `SFR_CKCON_ADDR);

    uart0_baud_gen baud (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .mode_in(mode),
        .fast_m0_in(sm_ff[0]),
        .baud_double_in(baud_double_in),
        .t1_fast_in(t1m_ff),
        .timer_one_ovf_in(timer_one_ovf_in),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control and status register
    // Multiprocessor filter drops address-less frames
    assign rx_accept = async_done_ff && !ri_ff && (!sm_ff[0] || rx_sh_ff[8]);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {sm_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff} <= `SCON_RESET;
            t1m_ff <= `CKCON_T1M_RESET;
        end else begin
            if (wr_scon) begin
                sm_ff <= sfr_wdata_in[`SCON_SM0_BIT:`SCON_SM2_BIT];
                ren_ff <= sfr_wdata_in[`SCON_REN_BIT];
                tb8_ff <= sfr_wdata_in[`SCON_TB8_BIT];
            end
            if (wr_ckcon) begin
                t1m_ff <= sfr_wdata_in[`CKCON_T1M_BIT];
            end
            if (rx_accept) begin
                rb8_ff <= rx_sh_ff[8];
            end else if (wr_scon) begin
                rb8_ff <= sfr_wdata_in[`SCON_RB8_BIT];
            end
            // Set beats a software clear in the same cycle
            ti_ff <= ti_set_ff || (wr_scon ? sfr_wdata_in[`SCON_TI_BIT] : ti_ff);
            ri_ff <= rx_accept || m0_done_ff
                     || (wr_scon ? sfr_wdata_in[`SCON_RI_BIT] : ri_ff);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_buf_ff <= `SBUF_RESET;
        end else if (m0_done_ff) begin
            rx_buf_ff <= tx_sh_ff[7:0];
        end else if (rx_accept) begin
            rx_buf_ff <= rx_sh_ff[7:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd_in) begin
            case (sfr_addr_in)
                `SFR_SCON_ADDR: rdata_ff <= {sm_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff};
                `SFR_SBUF_ADDR: rdata_ff <= rx_buf_ff;
                `SFR_CKCON_ADDR: rdata_ff <= 8'(t1m_ff) << `CKCON_T1M_BIT;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive pin synchroniser; a change counts once stages 2 and 3 agree
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {rxd_s1_ff, rxd_s2_ff, rxd_s3_ff, rxd_q_ff, rxd_d_ff} <= 5'h1f;
        end else begin
            rxd_s1_ff <= rxd_in;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_s3_ff <= rxd_s2_ff;
            if (rxd_s2_ff == rxd_s3_ff) begin
                rxd_q_ff <= rxd_s3_ff;
            end
            rxd_d_ff <= rxd_q_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter and mode 0 shifter (mode 0 is half duplex, so shared)
    assign bit_end = tick.sample16 && (tx_sub_ff == 4'hf);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_st_ff <= uart0_pkg::TX_IDLE;
            tx_sh_ff <= 11'h7ff;
            tx_cnt_ff <= 4'h0;
            tx_sub_ff <= 4'h0;
            m0_phase_ff <= 1'b0;
            txd_ff <= 1'b1;
            rxd_o_ff <= 1'b1;
            rxd_oe_ff <= 1'b0;
            ti_set_ff <= 1'b0;
            m0_done_ff <= 1'b0;
        end else begin
            ti_set_ff <= 1'b0;
            m0_done_ff <= 1'b0;
            case (tx_st_ff)
                uart0_pkg::TX_IDLE: begin
                    m0_phase_ff <= 1'b0;
                    tx_sub_ff <= 4'h0;
                    // Writes while busy are dropped; software waits for done
                    if (wr_sbuf && mode == 2'b00) begin
                        tx_st_ff <= uart0_pkg::TX_M0OUT;
                        tx_sh_ff <= {3'b111, sfr_wdata_in};
                        tx_cnt_ff <= 4'(`M0_BITS);
                        txd_ff <= 1'b0;
                        rxd_o_ff <= sfr_wdata_in[0];
                        rxd_oe_ff <= 1'b1;
                    end else if (wr_sbuf) begin
                        tx_st_ff <= uart0_pkg::TX_ASYNC;
                        if (mode[1]) begin
                            tx_sh_ff <= {1'b1, tb8_ff, sfr_wdata_in, 1'b0};
                            tx_cnt_ff <= 4'(`FRAME_9_BITS);
                        end else begin
                            tx_sh_ff <= {2'b11, sfr_wdata_in, 1'b0};
                            tx_cnt_ff <= 4'(`FRAME_8_BITS);
                        end
                        txd_ff <= 1'b0;
                    end else if (mode == 2'b00 && ren_ff && !ri_ff && tick.m0_half) begin
                        tx_st_ff <= uart0_pkg::TX_M0IN;
                        tx_cnt_ff <= 4'(`M0_BITS);
                        txd_ff <= 1'b0;
                        rxd_oe_ff <= 1'b0;
                    end
                end
                uart0_pkg::TX_M0OUT, uart0_pkg::TX_M0IN: begin
                    if (tick.m0_half && !m0_phase_ff) begin
                        txd_ff <= 1'b1;
                        m0_phase_ff <= 1'b1;
                    end else if (tick.m0_half) begin
                        m0_phase_ff <= 1'b0;
                        // Sampled at bit end, as the pin synchroniser outlasts a fast half bit
                        if (tx_st_ff == uart0_pkg::TX_M0IN) begin
                            tx_sh_ff <= {3'b111, rxd_now, tx_sh_ff[7:1]};
                        end
                        if (tx_cnt_ff == 4'h1) begin
                            tx_st_ff <= uart0_pkg::TX_IDLE;
                            rxd_oe_ff <= 1'b0;
                            rxd_o_ff <= 1'b1;
                            ti_set_ff <= (tx_st_ff == uart0_pkg::TX_M0OUT);
                            m0_done_ff <= (tx_st_ff == uart0_pkg::TX_M0IN);
                        end else begin
                            txd_ff <= 1'b0;
                            tx_cnt_ff <= tx_cnt_ff - 4'h1;
                            if (tx_st_ff == uart0_pkg::TX_M0OUT) begin
                                tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                                rxd_o_ff <= tx_sh_ff[1];
                            end
                        end
                    end
                end
                uart0_pkg::TX_ASYNC: begin
                    if (tick.sample16) begin
                        tx_sub_ff <= tx_sub_ff + 4'h1;
                    end
                    if (bit_end) begin
                        tx_cnt_ff <= tx_cnt_ff - 4'h1;
                        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                        txd_ff <= tx_sh_ff[1];
                        ti_set_ff <= (tx_cnt_ff == 4'h2);
                        if (tx_cnt_ff == 4'h1) begin
                            tx_st_ff <= uart0_pkg::TX_IDLE;
                            txd_ff <= 1'b1;
                        end
                    end
                end
                default: tx_st_ff <= uart0_pkg::TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous receiver, 16x oversampled, 2-of-3 vote mid bit
    assign rxd_now = (rxd_s2_ff == rxd_s3_ff) ? rxd_s3_ff : rxd_q_ff;
    assign maj = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & rxd_q_ff) | (vote_ff[1] & rxd_q_ff);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_st_ff <= uart0_pkg::RX_IDLE;
            rx_sub_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_sh_ff <= 9'h000;
            vote_ff <= 3'h0;
            async_done_ff <= 1'b0;
        end else begin
            async_done_ff <= 1'b0;
            if (!ren_ff || mode == 2'b00) begin
                rx_st_ff <= uart0_pkg::RX_IDLE;
            end else if (rx_st_ff == uart0_pkg::RX_IDLE) begin
                rx_sub_ff <= 4'h0;
                rx_cnt_ff <= 4'h0;
                if (rxd_d_ff && !rxd_q_ff) begin
                    rx_st_ff <= uart0_pkg::RX_START;
                end
            end else if (tick.sample16) begin
                rx_sub_ff <= rx_sub_ff + 4'h1;
                if (rx_sub_ff == 4'h7 || rx_sub_ff == 4'h8) begin
                    vote_ff <= {vote_ff[1:0], rxd_q_ff};
                end
                if (rx_sub_ff == 4'h9) begin
                    if (rx_st_ff == uart0_pkg::RX_START) begin
                        // A glitch shorter than half a bit is not a start
                        rx_st_ff <= maj ? uart0_pkg::RX_IDLE : uart0_pkg::RX_BITS;
                    end else begin
                        rx_sh_ff <= {maj, rx_sh_ff[8:1]};
                        rx_cnt_ff <= rx_cnt_ff + 4'h1;
                        if (rx_cnt_ff == 4'(`ASYNC_RX_BITS - 1)) begin
                            rx_st_ff <= uart0_pkg::RX_IDLE;
                            async_done_ff <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    assign sfr_rdata_out = rdata_ff;
    assign timer_one_tick_out = tick.t1_tick;
    assign txd_out = txd_ff;
    assign rxd_out = rxd_o_ff;
    assign rxd_oe_out = rxd_oe_ff;

    ////////////////////////////////////////////////////////////////////////
    ti_sticky_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ti_ff && !wr_scon |=> ti_ff) else $error("transmit done cleared by hardware");

    ri_sticky_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ri_ff && !wr_scon |=> ri_ff) else $error("receive done cleared by hardware");

    ren_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !ren_ff |=> rx_st_ff == uart0_pkg::RX_IDLE) else $error("receiver active while off");

    tb8_frame_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_sbuf && tx_st_ff == uart0_pkg::TX_IDLE && mode[1]
        |=> tx_sh_ff[9] == $past(tb8_ff) && tx_cnt_ff == 4'd11)
        else $error("ninth transmit bit not framed");

    ti_m0_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        tx_st_ff == uart0_pkg::TX_M0OUT && tick.m0_half && m0_phase_ff && tx_cnt_ff == 4'h1
        |=> ##1 ti_ff) else $error("mode 0 transmit done missing");

    ti_async_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        tx_st_ff == uart0_pkg::TX_ASYNC && bit_end && tx_cnt_ff == 4'h2
        |=> txd_ff ##1 ti_ff) else $error("transmit done not at stop bit");

    mp_filter_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        async_done_ff && !ri_ff && sm_ff[0] && !rx_sh_ff[8] && !wr_scon
        |=> !ri_ff && $stable(rx_buf_ff)) else $error("frame accepted without ninth bit");

    sbuf_read_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_rd_in && sfr_addr_in == `SFR_SBUF_ADDR |=> sfr_rdata_out == $past(rx_buf_ff))
        else $error("buffer read not receive buffer");

endmodule

// file: testbench/uart0_remote.sv
`timescale 1ns/1ps
module uart0_remote (
    input wire logic ref_clk_in,
    input wire logic txd_in,
    input wire logic line_in,
    input wire logic sync_en_in,
    output logic line_out
);
    int bit_len = 32;
    int sync_idx = 0;
    logic [7:0] sync_byte = 8'h00;
    logic [10:0] got = 11'h000;
    initial line_out = 1'b1;
    ////////////////////////////////////////////////////////////////
    // Start bit, then n bits LSB first; line idles high
    task automatic send(input logic [9:0] bits, input int n);
        line_out <= 1'b0;
        repeat (bit_len) @(posedge ref_clk_in);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (bit_len) @(posedge ref_clk_in);
        end
        line_out <= 1'b1;
    endtask
    // Mid-bit sampling, so a wrong bit time shows as wrong data
    task automatic recv(input int n);
        @(negedge txd_in);
        repeat (bit_len / 2) @(posedge ref_clk_in);
        for (int i = 0; i < n; i++) begin
            got[i] = txd_in;
            repeat (bit_len) @(posedge ref_clk_in);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Shift clock from the device: data moves on its falling edge
    always @(negedge txd_in) begin
        if (sync_en_in) begin
            line_out <= sync_byte[sync_idx[2:0]];
            sync_idx <= sync_idx + 1;
        end
    end
    always @(posedge txd_in) begin
        if (sync_en_in) begin
            got <= {line_in, got[10:1]};
        end
    end
endmodule

// file: testbench/tb_serial_port_zero_uart.sv
`timescale 1ns/1ps
module tb_serial_port_zero_uart;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic baud_double = 1'b1;
    logic ovf = 1'b0;
    logic sync_en = 1'b0;
    logic tick;
    logic rxd_out;
    logic rxd_oe;
    logic txd;
    logic far_line;
    logic rxd_line;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int ticks = 0;
    int t0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    // Device wins the shared data line only while it drives
    assign rxd_line = rxd_oe ? rxd_out : far_line;
    serial_port_zero_uart serial_port_zero_uart_inst (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .sfr_addr_in(sfr_addr),
        .sfr_wr_in(sfr_wr),
        .sfr_rd_in(sfr_rd),
        .sfr_wdata_in(sfr_wdata),
        .sfr_rdata_out(sfr_rdata),
        .baud_double_in(baud_double),
        .timer_one_ovf_in(ovf),
        .timer_one_tick_out(tick),
        .rxd_in(rxd_line),
        .rxd_out(rxd_out),
        .rxd_oe_out(rxd_oe),
        .txd_out(txd)
    );
    uart0_remote uart0_remote_inst (
        .ref_clk_in(ref_clk_in),
        .txd_in(txd),
        .line_in(rxd_line),
        .sync_en_in(sync_en),
        .line_out(far_line)
    );
    // Overflow every 2 clocks: 32 clocks a bit with doubling on
    always @(posedge ref_clk_in) begin
        ovf <= ~ovf;
        ticks <= ticks + int'(tick);
        cyc <= cyc + 1;
    end
    always @(posedge ref_clk_in) begin
        if (cyc > 20000) begin
            err_count++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [10:0] e, input logic [10:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk_in);
        sfr_wr <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk_in);
        sfr_rd <= 1'b0;
        @(posedge ref_clk_in);
        d = sfr_rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string name);
        logic [7:0] r;
        rd(a, r);
        chk(name, 11'(e), 11'(r));
    endtask
    // Bounded poll of the control/status flags
    task automatic wait_flag(input logic [7:0] m);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 3000 && (s & m) == 8'h00; i++) begin
            rd(8'h98, s);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        rc(8'h98, 8'h00, "control");
        rc(8'h99, 8'h00, "buffer");
        rc(8'h8e, 8'h00, "clock select");
        rc(8'h55, 8'h00, "unmapped");
        t0 = ticks;
        repeat (96) @(posedge ref_clk_in);
        chk("ticks slow", 11'd8, 11'(ticks - t0));
        wr(8'h8e, 8'hff);
        rc(8'h8e, 8'h10, "clock select");
        t0 = ticks;
        repeat (96) @(posedge ref_clk_in);
        chk("ticks fast", 11'd24, 11'(ticks - t0));
        // Mode 2 without doubling: 64 clocks a bit
        baud_double <= 1'b0;
        uart0_remote_inst.bit_len = 64;
        wr(8'h98, 8'h88);
        fork
            wr(8'h99, 8'ha5);
            uart0_remote_inst.recv(11);
        join
        chk("mode 2 frame", 11'h74a, uart0_remote_inst.got);
        rc(8'h98, 8'h8a, "transmit done");
        repeat (200) @(posedge ref_clk_in);
        rc(8'h98, 8'h8a, "transmit done held");
        wr(8'h98, 8'h88);
        rc(8'h98, 8'h88, "transmit done cleared");
        baud_double <= 1'b1;
        uart0_remote_inst.bit_len = 32;
        wr(8'h98, 8'h90);
        uart0_remote_inst.send(10'h33c, 10);
        wait_flag(8'h01);
        rc(8'h98, 8'h95, "mode 2 status");
        rc(8'h99, 8'h3c, "mode 2 data");
        // Address filter: ninth bit 0 is dropped
        wr(8'h98, 8'hb0);
        uart0_remote_inst.send(10'h212, 10);
        repeat (64) @(posedge ref_clk_in);
        rc(8'h98, 8'hb0, "filtered status");
        uart0_remote_inst.send(10'h321, 10);
        wait_flag(8'h01);
        rc(8'h98, 8'hb5, "address status");
        rc(8'h99, 8'h21, "address data");
        wr(8'h98, 8'h50);
        uart0_remote_inst.send(10'h181, 9);
        wait_flag(8'h01);
        rc(8'h98, 8'h55, "mode 1 status");
        rc(8'h99, 8'h81, "mode 1 data");
        wr(8'h98, 8'h40);
        fork
            wr(8'h99, 8'h5a);
            uart0_remote_inst.recv(10);
        join
        chk("mode 1 frame", 11'h2b4, 11'(uart0_remote_inst.got[9:0]));
        uart0_remote_inst.send(10'h1ff, 9);
        repeat (64) @(posedge ref_clk_in);
        rc(8'h98, 8'h42, "receive disabled");
        // Mode 3 without doubling: every second overflow, 64 clocks a bit
        baud_double <= 1'b0;
        uart0_remote_inst.bit_len = 64;
        wr(8'h98, 8'hc8);
        fork
            wr(8'h99, 8'h3c);
            uart0_remote_inst.recv(11);
        join
        chk("mode 3 frame", 11'h678, uart0_remote_inst.got);
        rc(8'h98, 8'hca, "mode 3 status");
        // Mode 0 slow transmit, then fast receive
        uart0_remote_inst.sync_byte = 8'hc3;
        sync_en <= 1'b1;
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h96);
        wait_flag(8'h02);
        chk("mode 0 out", 11'h096, 11'(uart0_remote_inst.got[10:3]));
        uart0_remote_inst.sync_idx = 0;
        wr(8'h98, 8'h30);
        wait_flag(8'h01);
        rc(8'h98, 8'h31, "mode 0 status");
        rc(8'h99, 8'hc3, "mode 0 data");
        end_of_test();
    end
endmodule
